//--- verilog/sysreg_pkg.sv
package sysreg_pkg;
	// Register byte offsets (word aligned)
	localparam logic [7:0] OFS_DMA_EVENT_SELECT   = 8'h00;
	localparam logic [7:0] OFS_HOST_PORT_CONTROL  = 8'h04;
	localparam logic [7:0] OFS_CHIP_ID            = 8'h08;
	localparam logic [7:0] OFS_VIDEO_DAC_SETUP    = 8'h0C;
	localparam logic [7:0] OFS_TIMER_INPUT_SELECT = 8'h10;
	localparam logic [7:0] OFS_USB_PHY_SETUP      = 8'h14;
	localparam logic [7:0] OFS_ASSORTED_CONTROL   = 8'h18;

	// Writable field masks per register
	localparam logic [31:0] MASK_DMA_EVENT  = 32'h0000_001F;
	localparam logic [31:0] MASK_HOST_PORT  = 32'h0000_03FF;
	localparam logic [31:0] MASK_VIDEO_DAC  = 32'h0000_003F;
	localparam logic [31:0] MASK_TIMER_IN   = 32'h0000_0003;
	localparam logic [31:0] MASK_USB_PHY    = 32'h0000_FED3;
	localparam logic [31:0] MASK_ASSORTED   = 32'h0000_0CF0;

	// Reset values of writable fields
	localparam logic [31:0] RST_DMA_EVENT   = 32'h0000_0000;
	localparam logic [31:0] RST_HOST_PORT   = 32'h0000_0080;
	localparam logic [31:0] RST_VIDEO_DAC   = 32'h0000_0000;
	localparam logic [31:0] RST_TIMER_IN    = 32'h0000_0000;
	localparam logic [31:0] RST_USB_PHY     = 32'h0000_00C3;
	localparam logic [31:0] RST_ASSORTED    = 32'h0000_0010;

	// Read-only status bit positions
	localparam int POS_VIDEO_SHORT  = 31;
	localparam int POS_VIDEO_CONN   = 30;
	localparam int POS_PHY_GOOD     = 8;
	localparam int POS_VBUS_PRESENT = 5;
	localparam int POS_BOOT_LO      = 8;

	// Identification fields, values arbitrary
	localparam logic [3:0]  ID_SILICON_REVISION = 4'h1;
	localparam logic [15:0] ID_PART_CODE        = 16'h5A5A;
	localparam logic [10:0] ID_MAKER_CODE       = 11'h123;
	localparam logic [31:0] ID_WORD = {ID_SILICON_REVISION, ID_PART_CODE, ID_MAKER_CODE, 1'b1};
endpackage

//--- verilog/sysreg_top.sv
`timescale 1ns/10ps
// How it works
// - Bits 4,3 pick UART or SPI3 events
// - Bit 2 picks image or HD coprocessor
// - Bits 1,0 pick serial or voice codec
// - Ctrl write owner needs address owner too
// - Bit 8 gives address write owner
// - Burst timeout byte resets to 0x80
// - ID word read only, fixed fields
// - Bit 31 flags video short
// - Bit 30 flags video cable connected
// - DAC mode, detect enable, power bits
// - Timer input pin pair selects
// - PHY frequency code, reserved codes unused
// - PHY clock source and data invert
// - PHY good and VBUS status read only
// - Comparator enables reset to one
// - PLL override and power off bits
// - Bus inhibit bits around clock stop
// - Boot outcome status field
// - Transfer controller burst size select
// - Clock stop handshake bypass bits
// - Timer two watchdog, resets to one
module sysreg_top (
	input  wire logic        i_core_clk,
	input  wire logic        i_resetn,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic [31:0]      o_rdata,
	input  wire logic        i_video_short,
	input  wire logic        i_video_connect,
	input  wire logic        i_phy_power_clock_good,
	input  wire logic        i_vbus_present,
	input  wire logic [1:0]  i_boot_outcome,
	output logic             o_dma_sel_uart_tx_or_spi_rx,
	output logic             o_dma_sel_uart_rx_or_spi_tx,
	output logic             o_dma_sel_coproc_event,
	output logic             o_dma_sel_serial_receive,
	output logic             o_dma_sel_serial_transmit,
	output logic             o_host_ctrl_write_by_cpu,
	output logic             o_host_addr_write_by_cpu,
	output logic [7:0]       o_host_burst_timeout,
	output logic             o_channel_c_hd_select,
	output logic             o_connect_detect_enable,
	output logic             o_sd_buffer_power,
	output logic [2:0]       o_dac_channel_power,
	output logic             o_timer_pin_pair_b_sel,
	output logic             o_timer_pin_pair_a_sel,
	output logic [3:0]       o_phy_clock_frequency,
	output logic             o_phy_data_invert,
	output logic [1:0]       o_phy_clock_source,
	output logic             o_session_end_comp_enable,
	output logic             o_vbus_comp_enable,
	output logic             o_phy_pll_suspend_override,
	output logic             o_otg_analog_power_off,
	output logic             o_phy_power_off,
	output logic             o_card_bus_inhibit,
	output logic             o_video_coproc_bus_inhibit,
	output logic             o_transfer_ctrl1_burst_size,
	output logic             o_dma_clock_stop_bypass,
	output logic             o_serial_clock_stop_bypass,
	output logic             o_timer_two_watchdog_select
);

	// Control registers, only writable bits ever set
	logic [31:0] dma_event_select;
	logic [31:0] host_port_control;
	logic [31:0] video_dac_setup;
	logic [31:0] timer_input_select;
	logic [31:0] usb_phy_setup;
	logic [31:0] assorted_control;
	logic [31:0] next_dma_event_select;
	logic [31:0] next_host_port_control;
	logic [31:0] next_video_dac_setup;
	logic [31:0] next_timer_input_select;
	logic [31:0] next_usb_phy_setup;
	logic [31:0] next_assorted_control;

	// Status synchronisers: first stage feeds only the second
	logic [5:0]  stat_meta;
	logic [5:0]  stat_sync;

	// Read path
	logic [31:0] next_rdata;
	logic [31:0] rd_word;

	// Two flops on every pin-level status input
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			stat_meta <= 6'h00;
			stat_sync <= 6'h00;
		end else begin
			stat_meta <= {i_video_short, i_video_connect, i_phy_power_clock_good,
				i_vbus_present, i_boot_outcome};
			stat_sync <= stat_meta;
		end
	end

	// Write decode; each register keeps only its writable mask
	always_comb begin
		next_dma_event_select   = dma_event_select;
		next_host_port_control  = host_port_control;
		next_video_dac_setup    = video_dac_setup;
		next_timer_input_select = timer_input_select;
		next_usb_phy_setup      = usb_phy_setup;
		next_assorted_control   = assorted_control;
		if (i_wr) begin
			unique case (i_addr)
				sysreg_pkg::OFS_DMA_EVENT_SELECT: begin
					next_dma_event_select = i_wdata & sysreg_pkg::MASK_DMA_EVENT;
				end
				sysreg_pkg::OFS_HOST_PORT_CONTROL: begin
					next_host_port_control = i_wdata & sysreg_pkg::MASK_HOST_PORT;
				end
				sysreg_pkg::OFS_VIDEO_DAC_SETUP: begin
					next_video_dac_setup = i_wdata & sysreg_pkg::MASK_VIDEO_DAC;
				end
				sysreg_pkg::OFS_TIMER_INPUT_SELECT: begin
					next_timer_input_select = i_wdata & sysreg_pkg::MASK_TIMER_IN;
				end
				sysreg_pkg::OFS_USB_PHY_SETUP: begin
					next_usb_phy_setup = i_wdata & sysreg_pkg::MASK_USB_PHY;
				end
				sysreg_pkg::OFS_ASSORTED_CONTROL: begin
					next_assorted_control = i_wdata & sysreg_pkg::MASK_ASSORTED;
				end
				default: begin
					next_dma_event_select = dma_event_select;
				end
			endcase
		end
	end

	// Register the control state
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			dma_event_select   <= sysreg_pkg::RST_DMA_EVENT;
			host_port_control  <= sysreg_pkg::RST_HOST_PORT;
			video_dac_setup    <= sysreg_pkg::RST_VIDEO_DAC;
			timer_input_select <= sysreg_pkg::RST_TIMER_IN;
			usb_phy_setup      <= sysreg_pkg::RST_USB_PHY;
			assorted_control   <= sysreg_pkg::RST_ASSORTED;
		end else begin
			dma_event_select   <= next_dma_event_select;
			host_port_control  <= next_host_port_control;
			video_dac_setup    <= next_video_dac_setup;
			timer_input_select <= next_timer_input_select;
			usb_phy_setup      <= next_usb_phy_setup;
			assorted_control   <= next_assorted_control;
		end
	end

	// Read mux; status bits come from synchronised inputs, never from storage
	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (i_addr)
			sysreg_pkg::OFS_DMA_EVENT_SELECT:   rd_word = dma_event_select;
			sysreg_pkg::OFS_HOST_PORT_CONTROL:  rd_word = host_port_control;
			sysreg_pkg::OFS_CHIP_ID:            rd_word = sysreg_pkg::ID_WORD;
			sysreg_pkg::OFS_VIDEO_DAC_SETUP: begin
				rd_word = video_dac_setup;
				rd_word[sysreg_pkg::POS_VIDEO_SHORT] = stat_sync[5];
				rd_word[sysreg_pkg::POS_VIDEO_CONN] = stat_sync[4];
			end
			sysreg_pkg::OFS_TIMER_INPUT_SELECT: rd_word = timer_input_select;
			sysreg_pkg::OFS_USB_PHY_SETUP: begin
				rd_word = usb_phy_setup;
				rd_word[sysreg_pkg::POS_PHY_GOOD]     = stat_sync[3];
				rd_word[sysreg_pkg::POS_VBUS_PRESENT] = stat_sync[2];
			end
			sysreg_pkg::OFS_ASSORTED_CONTROL: begin
				rd_word = assorted_control;
				rd_word[sysreg_pkg::POS_BOOT_LO +: 2] = stat_sync[1:0];
			end
			// Unmapped reads return zero
			default: rd_word = 32'h0000_0000;
		endcase
		next_rdata = i_rd ? rd_word : 32'h0000_0000;
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			o_rdata <= 32'h0000_0000;
		end else begin
			o_rdata <= next_rdata;
		end
	end

	// Next values of the control outputs
	// Outputs trail their fields by one cycle; readback comes from the fields, so software never sees it
	logic       next_dma_sel_uart_tx_or_spi_rx; // UART transmit or SPI receive
	logic       next_dma_sel_uart_rx_or_spi_tx; // UART receive or SPI transmit
	logic       next_dma_sel_coproc_event;      // Image or HD coprocessor event
	logic       next_dma_sel_serial_receive;    // Serial or voice codec receive
	logic       next_dma_sel_serial_transmit;   // Serial or voice codec transmit
	logic       next_host_ctrl_write_by_cpu;    // Gated control ownership
	logic       next_host_addr_write_by_cpu;    // Address ownership
	logic [7:0] next_host_burst_timeout;        // Burst write timeout
	logic       next_channel_c_hd_select;       // Channel C mode
	logic       next_connect_detect_enable;     // Cable detect enable
	logic       next_sd_buffer_power;           // SD buffer running
	logic [2:0] next_dac_channel_power;         // Channels C, B, A running
	logic       next_timer_pin_pair_b_sel;      // Third or fourth pin
	logic       next_timer_pin_pair_a_sel;      // First or second pin
	logic [3:0] next_phy_clock_frequency;       // PHY reference code
	logic       next_phy_data_invert;           // PHY data polarity
	logic [1:0] next_phy_clock_source;          // PHY clock source
	logic       next_session_end_comp_enable;   // Session end comparator
	logic       next_vbus_comp_enable;          // Other VBUS comparators
	logic       next_phy_pll_suspend_override;  // Keep PHY PLL running
	logic       next_otg_analog_power_off;      // OTG analog block off
	logic       next_phy_power_off;             // PHY off
	logic       next_card_bus_inhibit;          // Card controller fenced
	logic       next_video_coproc_bus_inhibit;  // Video coprocessor fenced
	logic       next_transfer_ctrl1_burst_size; // Burst length select
	logic       next_dma_clock_stop_bypass;     // DMA clock stop bypass
	logic       next_serial_clock_stop_bypass;  // Serial clock stop bypass
	logic       next_timer_two_watchdog_select; // Timer two as watchdog

	// Field to output mapping; the owner gate is the only logic on this path
	// Reserved frequency codes pass through: keeping them out is left to software
	// Bus inhibits are plain levels; ordering them around clock stops is software's job
	always_comb begin
		next_dma_sel_uart_tx_or_spi_rx = dma_event_select[4];
		next_dma_sel_uart_rx_or_spi_tx = dma_event_select[3];
		next_dma_sel_coproc_event      = dma_event_select[2];
		next_dma_sel_serial_receive    = dma_event_select[1];
		next_dma_sel_serial_transmit   = dma_event_select[0];
		next_host_ctrl_write_by_cpu    = host_port_control[9] & host_port_control[8];
		next_host_addr_write_by_cpu    = host_port_control[8];
		next_host_burst_timeout        = host_port_control[7:0];
		next_channel_c_hd_select       = video_dac_setup[5];
		next_connect_detect_enable     = video_dac_setup[4];
		next_sd_buffer_power           = video_dac_setup[3];
		next_dac_channel_power         = video_dac_setup[2:0];
		next_timer_pin_pair_b_sel      = timer_input_select[1];
		next_timer_pin_pair_a_sel      = timer_input_select[0];
		next_phy_clock_frequency       = usb_phy_setup[15:12];
		next_phy_data_invert           = usb_phy_setup[11];
		next_phy_clock_source          = usb_phy_setup[10:9];
		next_session_end_comp_enable   = usb_phy_setup[7];
		next_vbus_comp_enable          = usb_phy_setup[6];
		next_phy_pll_suspend_override  = usb_phy_setup[4];
		next_otg_analog_power_off      = usb_phy_setup[1];
		next_phy_power_off             = usb_phy_setup[0];
		next_card_bus_inhibit          = assorted_control[11];
		next_video_coproc_bus_inhibit  = assorted_control[10];
		next_transfer_ctrl1_burst_size = assorted_control[7];
		next_dma_clock_stop_bypass     = assorted_control[6];
		next_serial_clock_stop_bypass  = assorted_control[5];
		next_timer_two_watchdog_select = assorted_control[4];
	end

	// Every control output comes straight from a flop, so no decode glitch reaches the units it steers
	// Reset values are the fields of the reset words, so outputs agree with a readback after reset
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			// Event routing
			o_dma_sel_uart_tx_or_spi_rx <= sysreg_pkg::RST_DMA_EVENT[4];
			o_dma_sel_uart_rx_or_spi_tx <= sysreg_pkg::RST_DMA_EVENT[3];
			o_dma_sel_coproc_event      <= sysreg_pkg::RST_DMA_EVENT[2];
			o_dma_sel_serial_receive    <= sysreg_pkg::RST_DMA_EVENT[1];
			o_dma_sel_serial_transmit   <= sysreg_pkg::RST_DMA_EVENT[0];
			// Host port ownership
			o_host_ctrl_write_by_cpu    <= sysreg_pkg::RST_HOST_PORT[9] & sysreg_pkg::RST_HOST_PORT[8];
			o_host_addr_write_by_cpu    <= sysreg_pkg::RST_HOST_PORT[8];
			o_host_burst_timeout        <= sysreg_pkg::RST_HOST_PORT[7:0];
			// Video DAC
			o_channel_c_hd_select       <= sysreg_pkg::RST_VIDEO_DAC[5];
			o_connect_detect_enable     <= sysreg_pkg::RST_VIDEO_DAC[4];
			o_sd_buffer_power           <= sysreg_pkg::RST_VIDEO_DAC[3];
			o_dac_channel_power         <= sysreg_pkg::RST_VIDEO_DAC[2:0];
			// Timer pins
			o_timer_pin_pair_b_sel      <= sysreg_pkg::RST_TIMER_IN[1];
			o_timer_pin_pair_a_sel      <= sysreg_pkg::RST_TIMER_IN[0];
			// USB PHY clocking and comparators
			o_phy_clock_frequency       <= sysreg_pkg::RST_USB_PHY[15:12];
			o_phy_data_invert           <= sysreg_pkg::RST_USB_PHY[11];
			o_phy_clock_source          <= sysreg_pkg::RST_USB_PHY[10:9];
			o_session_end_comp_enable   <= sysreg_pkg::RST_USB_PHY[7];
			o_vbus_comp_enable          <= sysreg_pkg::RST_USB_PHY[6];
			// PLL override and power off
			o_phy_pll_suspend_override  <= sysreg_pkg::RST_USB_PHY[4];
			o_otg_analog_power_off      <= sysreg_pkg::RST_USB_PHY[1];
			o_phy_power_off             <= sysreg_pkg::RST_USB_PHY[0];
			// Bus inhibits, burst size, clock stop bypasses and watchdog
			o_card_bus_inhibit          <= sysreg_pkg::RST_ASSORTED[11];
			o_video_coproc_bus_inhibit  <= sysreg_pkg::RST_ASSORTED[10];
			o_transfer_ctrl1_burst_size <= sysreg_pkg::RST_ASSORTED[7];
			o_dma_clock_stop_bypass     <= sysreg_pkg::RST_ASSORTED[6];
			o_serial_clock_stop_bypass  <= sysreg_pkg::RST_ASSORTED[5];
			o_timer_two_watchdog_select <= sysreg_pkg::RST_ASSORTED[4];
		end else begin
			// Event routing
			o_dma_sel_uart_tx_or_spi_rx <= next_dma_sel_uart_tx_or_spi_rx;
			o_dma_sel_uart_rx_or_spi_tx <= next_dma_sel_uart_rx_or_spi_tx;
			o_dma_sel_coproc_event      <= next_dma_sel_coproc_event;
			o_dma_sel_serial_receive    <= next_dma_sel_serial_receive;
			o_dma_sel_serial_transmit   <= next_dma_sel_serial_transmit;
			// Host port
			o_host_ctrl_write_by_cpu    <= next_host_ctrl_write_by_cpu;
			o_host_addr_write_by_cpu    <= next_host_addr_write_by_cpu;
			o_host_burst_timeout        <= next_host_burst_timeout;
			// Video DAC
			o_channel_c_hd_select       <= next_channel_c_hd_select;
			o_connect_detect_enable     <= next_connect_detect_enable;
			o_sd_buffer_power           <= next_sd_buffer_power;
			o_dac_channel_power         <= next_dac_channel_power;
			// Timer pins
			o_timer_pin_pair_b_sel      <= next_timer_pin_pair_b_sel;
			o_timer_pin_pair_a_sel      <= next_timer_pin_pair_a_sel;
			// USB PHY clocking
			o_phy_clock_frequency       <= next_phy_clock_frequency;
			o_phy_data_invert           <= next_phy_data_invert;
			o_phy_clock_source          <= next_phy_clock_source;
			// USB PHY comparators and power
			o_session_end_comp_enable   <= next_session_end_comp_enable;
			o_vbus_comp_enable          <= next_vbus_comp_enable;
			o_phy_pll_suspend_override  <= next_phy_pll_suspend_override;
			o_otg_analog_power_off      <= next_otg_analog_power_off;
			o_phy_power_off             <= next_phy_power_off;
			// Bus inhibits
			o_card_bus_inhibit          <= next_card_bus_inhibit;
			o_video_coproc_bus_inhibit  <= next_video_coproc_bus_inhibit;
			// Burst, clock stop bypasses and watchdog
			o_transfer_ctrl1_burst_size <= next_transfer_ctrl1_burst_size;
			o_dma_clock_stop_bypass     <= next_dma_clock_stop_bypass;
			o_serial_clock_stop_bypass  <= next_serial_clock_stop_bypass;
			o_timer_two_watchdog_select <= next_timer_two_watchdog_select;
		end
	end

endmodule // sysreg_top

//--- bench/scr_props.sv
`timescale 1ns/10ps
// Port checks for the config register bank, single clock domain
module scr_props (
	input wire logic        i_core_clk,
	input wire logic        i_resetn,
	input wire logic [7:0]  i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic        o_dma_sel_uart_tx_or_spi_rx,
	input wire logic        o_dma_sel_uart_rx_or_spi_tx,
	input wire logic        o_dma_sel_coproc_event,
	input wire logic        o_dma_sel_serial_receive,
	input wire logic        o_dma_sel_serial_transmit,
	input wire logic        o_host_ctrl_write_by_cpu,
	input wire logic        o_host_addr_write_by_cpu,
	input wire logic [7:0]  o_host_burst_timeout,
	input wire logic        o_session_end_comp_enable,
	input wire logic        o_vbus_comp_enable,
	input wire logic        o_card_bus_inhibit,
	input wire logic        o_video_coproc_bus_inhibit,
	input wire logic        o_timer_two_watchdog_select
);
	default clocking @(posedge i_core_clk);
	endclocking
	// A reset aborts any write still on its way to the outputs
	default disable iff (!i_resetn);
	// Strobes aimed at one register
	sequence s_wr(logic [7:0] a);
		i_wr && i_addr == a;
	endsequence
	sequence s_rd(logic [7:0] a);
		i_rd && i_addr == a;
	endsequence
	a_dma_sel_follow: assert property (
		s_wr(8'h00) |-> ##2 {o_dma_sel_uart_tx_or_spi_rx, o_dma_sel_uart_rx_or_spi_tx, o_dma_sel_coproc_event,
		o_dma_sel_serial_receive, o_dma_sel_serial_transmit} == $past(i_wdata[4:0], 2))
		else $error("dma select outputs differ from write");
	a_ctrl_owner_gate: assert property (o_host_ctrl_write_by_cpu |-> o_host_addr_write_by_cpu)
		else $error("control owner without address owner");
	a_addr_owner_follow: assert property (
		s_wr(8'h04) |-> ##2 o_host_addr_write_by_cpu == $past(i_wdata[8], 2))
		else $error("address owner differs from write");
	a_timeout_follow: assert property (
		s_wr(8'h04) |-> ##2 o_host_burst_timeout == $past(i_wdata[7:0], 2))
		else $error("burst timeout differs from write");
	a_id_read_fixed: assert property (s_rd(8'h08) |=> o_rdata == sysreg_pkg::ID_WORD)
		else $error("identification word wrong");
	a_comp_reset_on: assert property (
		$rose(i_resetn) |-> o_session_end_comp_enable && o_vbus_comp_enable && o_host_burst_timeout == 8'h80)
		else $error("reset defaults wrong");
	a_wdt_reset_on: assert property ($rose(i_resetn) |-> o_timer_two_watchdog_select)
		else $error("watchdog select not set after reset");
	a_inhibit_follow: assert property (
		s_wr(8'h18) |-> ##2 {o_card_bus_inhibit, o_video_coproc_bus_inhibit} == $past(i_wdata[11:10], 2))
		else $error("bus inhibit outputs differ from write");
endmodule // scr_props

//--- bench/system_config_registers_test.sv
`timescale 1ns/10ps
// Self-checking bench: register bus tasks plus a mirror of the stored words
module system_config_registers_test;
	logic        i_core_clk = 1'b0;
	logic        i_resetn = 1'b0;
	logic [7:0]  i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0000_0000;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic [3:0]  pins = 4'h0;
	logic [1:0]  i_boot_outcome = 2'h0;
	logic [31:0] o_rdata;
	// All control outputs packed for one compare
	wire  [40:0] outs;
	logic [31:0] img [6];
	int          failures = 0;
	int          total_checks = 0;
	localparam logic [7:0] OFS [6] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h18};
	localparam logic [31:0] RSTV [6] = '{32'h0000_0000, 32'h0000_0080, 32'h0000_0000, 32'h0000_0000,
		32'h0000_00C3, 32'h0000_0010};
	localparam logic [31:0] MSK [6] = '{32'h0000_001F, 32'h0000_03FF, 32'h0000_003F, 32'h0000_0003,
		32'h0000_FED3, 32'h0000_0CF0};
	localparam logic [3:0] FQ [4] = '{4'h1, 4'h2, 4'h4, 4'h2};
	always #4 i_core_clk = ~i_core_clk;
	sysreg_top dut_u (.i_core_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_boot_outcome,
		.i_video_short(pins[0]), .i_video_connect(pins[1]), .i_phy_power_clock_good(pins[2]),
		.i_vbus_present(pins[3]), .o_dma_sel_uart_tx_or_spi_rx(outs[40]), .o_dma_sel_uart_rx_or_spi_tx(outs[39]),
		.o_dma_sel_coproc_event(outs[38]), .o_dma_sel_serial_receive(outs[37]),
		.o_dma_sel_serial_transmit(outs[36]), .o_host_ctrl_write_by_cpu(outs[35]),
		.o_host_addr_write_by_cpu(outs[34]), .o_host_burst_timeout(outs[33:26]),
		.o_channel_c_hd_select(outs[25]), .o_connect_detect_enable(outs[24]), .o_sd_buffer_power(outs[23]),
		.o_dac_channel_power(outs[22:20]), .o_timer_pin_pair_b_sel(outs[19]), .o_timer_pin_pair_a_sel(outs[18]),
		.o_phy_clock_frequency(outs[17:14]), .o_phy_data_invert(outs[13]), .o_phy_clock_source(outs[12:11]),
		.o_session_end_comp_enable(outs[10]), .o_vbus_comp_enable(outs[9]),
		.o_phy_pll_suspend_override(outs[8]), .o_otg_analog_power_off(outs[7]), .o_phy_power_off(outs[6]),
		.o_card_bus_inhibit(outs[5]), .o_video_coproc_bus_inhibit(outs[4]),
		.o_transfer_ctrl1_burst_size(outs[3]), .o_dma_clock_stop_bypass(outs[2]),
		.o_serial_clock_stop_bypass(outs[1]), .o_timer_two_watchdog_select(outs[0]));
	// Output levels the stored words should give; control owner needs address owner
	function automatic logic [40:0] exp_out();
		return {img[0][4:0], img[1][9] & img[1][8], img[1][8:0], img[2][5:0], img[3][1:0], img[4][15:9],
			img[4][7:6], img[4][4], img[4][1:0], img[5][11:10], img[5][7:4]};
	endfunction
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 chk("read data", e, o_rdata);
	endtask
	// Write, read back and compare all outputs; outputs trail the register by one edge
	task automatic wchk(input int i, input logic [31:0] d);
		wr(OFS[i], d);
		img[i] = d & MSK[i];
		rd(OFS[i], img[i]);
		chk("outputs", exp_out(), outs);
	endtask
	task automatic t_reset(input int n);
		@(posedge i_core_clk);
		i_resetn <= 1'b0;
		// Status pins quiet, so live status bits read zero against the reset image
		pins <= 4'h0;
		i_boot_outcome <= 2'h0;
		repeat (n) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		img = RSTV;
		#1 chk("outputs", exp_out(), outs);
		for (int i = 0; i < 6; i++) rd(OFS[i], RSTV[i]);
	endtask
	// Every writable field set then cleared, plus host owner and DAC words
	task automatic t_fields;
		for (int i = 0; i < 6; i++) wchk(i, MSK[i]);
		for (int i = 0; i < 6; i++) wchk(i, 32'h0000_0000);
		wchk(1, 32'h0000_0200);
		wchk(1, 32'h0000_0300);
		wchk(2, 32'h1019_41E7);
		wchk(2, 32'h1019_41DC);
		for (int k = 0; k < 4; k++) wchk(4, {16'h0000, FQ[k], k[0], k[1:0], 9'h0D3});
	endtask
	// Read-only places: identification, status bits, unmapped address
	task automatic t_status;
		wr(8'h08, 32'h0000_0000);
		rd(8'h08, sysreg_pkg::ID_WORD);
		wchk(4, img[4] | 32'h0000_0120);
		wr(8'h1C, 32'h0000_FFFF);
		rd(8'h1C, 32'h0000_0000);
		chk("outputs", exp_out(), outs);
		for (int b = 0; b < 4; b++) begin
			// Pins change on the rising edge, then two sync stages settle
			@(posedge i_core_clk);
			pins <= {b[1], b[0], b[1], b[0]};
			i_boot_outcome <= b[1:0];
			repeat (3) @(posedge i_core_clk);
			// Short pin (bit 31) follows b[0], connect pin (bit 30) follows b[1]
			rd(8'h0C, img[2] | {b[0], b[1], 30'h0000_0000});
			rd(8'h14, img[4] | {23'h00_0000, b[0], 2'h0, b[1], 5'h00});
			rd(8'h18, img[5] | {22'h00_0000, b[1:0], 8'h00});
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Watchdog far beyond the roughly 180 cycles the sequence needs
	initial begin
		#100000;
		failures++;
		wrap_up();
	end
	initial begin
		t_reset(20);
		t_fields();
		t_status();
		t_reset(2);
		wrap_up();
	end
endmodule // system_config_registers_test
bind sysreg_top scr_props u_props (.i_core_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
	.o_dma_sel_uart_tx_or_spi_rx, .o_dma_sel_uart_rx_or_spi_tx, .o_dma_sel_coproc_event,
	.o_dma_sel_serial_receive, .o_dma_sel_serial_transmit, .o_host_ctrl_write_by_cpu, .o_host_addr_write_by_cpu,
	.o_host_burst_timeout, .o_session_end_comp_enable, .o_vbus_comp_enable, .o_card_bus_inhibit,
	.o_video_coproc_bus_inhibit, .o_timer_two_watchdog_select);
